// ==== rtl/rwc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the reset and watchdog block
`ifndef RWC_REGS_SVH
`define RWC_REGS_SVH

`define RWC_OFS_CAUSE        8'h00
`define RWC_OFS_WDCTL        8'h04
`define RWC_ADDR_MSB         7

`define RWC_CAUSE_WD         3
`define RWC_CAUSE_UV         2
`define RWC_CAUSE_PIN        1
`define RWC_CAUSE_PWR        0
`define RWC_CAUSE_RST        4'h1

`define RWC_CTL_IRQ_FLAG     7
`define RWC_CTL_IRQ_EN       6
`define RWC_CTL_SEL_HI       5
`define RWC_CTL_CHG_EN       4
`define RWC_CTL_RST_EN       3
`define RWC_CTL_SEL_LO_MSB   2

`define RWC_CHG_WINDOW       3'h4
`define RWC_SEL_MAX          4'h9
`define RWC_WD_CNT_W         21

`define RWC_STRETCH_DEF      16384
`define RWC_WD_BASE_DEF      2048

`endif

// ==== rtl/rwc_pkg.sv ====
// Types shared by the reset and watchdog block
package rwc_pkg;
	// Positions of the pin, detector, oscillator and fuse levels inside the synchroniser vector
	typedef enum int {
		RWC_IN_PIN_N  = 0,
		RWC_IN_PWR    = 1,
		RWC_IN_UV     = 2,
		RWC_IN_OSC    = 3,
		RWC_IN_UV_EN  = 4,
		RWC_IN_PIN_DIS = 5,
		RWC_IN_AON    = 6
	} rwc_in_type;
	typedef logic [6:0] rwc_inv_type;
	typedef logic [3:0] rwc_sel_type;
	typedef logic [3:0] rwc_cause_type;
endpackage : rwc_pkg

// ==== rtl/rwc_reset_watchdog.sv ====
// Reset combiner, reset stretcher, cause flags and watchdog timer with an AHB-Lite register slave
//
// Summary of operation
// RULE_01 - During internal reset block registers return to initial values; release pulses a fetch start.
// RULE_02 - Pin reset output asserts combinationally from any raw source, no clock needed.
// RULE_03 - Internal reset is held a stretch period after all sources go quiet.
// RULE_04 - Sources are power-on, enabled pin, watchdog reset mode, enabled undervolt detector.
// RULE_05 - Pin low long enough resets even without clock; short pulses may be missed.
// RULE_06 - Pin reset disable fuse removes the pin as a reset source.
// RULE_07 - Power-on detector asserts reset at once; its release starts the stretch.
// RULE_08 - Enabled undervolt detector asserts reset at once; its release starts the stretch.
// RULE_09 - Watchdog reset is a one clock pulse; stretch starts after the pulse ends.
// RULE_10 - Bit 3 set by watchdog reset, cleared by power-on or writing zero.
// RULE_11 - Bit 2 set by undervolt reset, cleared by power-on or writing zero.
// RULE_12 - Bit 1 set by pin reset, cleared by power-on or writing zero.
// RULE_13 - Bit 0 set by power-on reset, cleared only by writing zero.
// RULE_14 - Reference enable is on when undervolt fuse, comparator select or converter enable.
// RULE_15 - Watchdog counter advances on edges of its own oscillator.
// RULE_16 - Firmware restarts the watchdog before time-out, else interrupt or reset follows.
// RULE_17 - Interrupt mode expiry raises an interrupt request usable as wake-up.
// RULE_18 - Combined mode: first expiry interrupts, a following expiry resets.
// RULE_19 - Always-on fuse forces reset enable to 1 and interrupt enable to 0.
// RULE_20 - Opening a change needs change enable and reset enable written one together.
// RULE_21 - Within four cycles one write sets reset enable and time-out; only then accepted.
// RULE_22 - Expiry at the selected count yields interrupt or reset per mode.
// RULE_23 - Change enable clears itself four cycles after being written one.
// RULE_24 - Reset enable reads set while bit 3 is set and cannot be cleared.
// RULE_25 - Watchdog interrupt flag clears on vector taken or software writing one.
// RULE_26 - Stretch length is a module parameter.
// RULE_27 - Asynchronous sources and the watchdog oscillator are synchronised into the clock domain.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "rwc_regs.svh"

module rwc_reset_watchdog
	import rwc_pkg::*;
#(
	parameter int STRETCH_CYCLES = `RWC_STRETCH_DEF,
	parameter int WD_BASE_CYCLES = `RWC_WD_BASE_DEF
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        extResetPinN,
	input  wire logic        powerupDetect,
	input  wire logic        undervoltDetect,
	input  wire logic        wdOscClk,
	input  wire logic        undervoltEnableFuse,
	input  wire logic        pinResetDisableFuse,
	input  wire logic        wdAlwaysOnFuse,
	input  wire logic        comparatorRefSelect,
	input  wire logic        adcEnable,
	input  wire logic        wdRestart,
	input  wire logic        wdIrqAck,
	output logic             resetN,
	output logic             fetchStart,
	output logic             wdIrqReq,
	output logic             refEnable
);
	localparam int SW = $clog2(STRETCH_CYCLES + 1);

	// Parameters the counters cannot serve are refused
	initial begin
		if (STRETCH_CYCLES < 1 || WD_BASE_CYCLES < 1 || WD_BASE_CYCLES > 2048)
			$error("rwc_reset_watchdog: unsupported parameter value");
	end

	typedef struct packed {
		rwc_inv_type               sync1;
		rwc_inv_type               sync2;
		logic                      oscPrev;
		logic [`RWC_WD_CNT_W-1:0]  wdCount;
		logic                      wdPulse;
		logic                      inReset;
		logic [SW-1:0]             stretchCnt;
		logic                      startPulse;
		rwc_cause_type             flags;
		logic                      wd_reset_enable;
		logic                      wd_irq_enable;
		logic                      irqFlag;
		rwc_sel_type               sel;
		logic [2:0]                ceCnt;
		logic                      selQ;
		logic                      writeQ;
		logic [`RWC_ADDR_MSB:0]    addrQ;
		logic [31:0]               rdata;
	} rwc_state_type;

	rwc_state_type r;
	rwc_state_type next_r;

	// Time-out count for a prescaler code; codes above the top one behave as the top one
	function automatic logic [`RWC_WD_CNT_W-1:0] rwcLimit(input rwc_sel_type s);
		rwc_sel_type c;
		c = (s > `RWC_SEL_MAX) ? `RWC_SEL_MAX : s;
		return `RWC_WD_CNT_W'(WD_BASE_CYCLES) << c;
	endfunction : rwcLimit

	rwc_inv_type rawIn;
	logic        rawActive;
	logic        pinAct;
	logic        pwrAct;
	logic        uvAct;
	logic        alwaysOn;
	logic        anySrc;
	logic        oscRise;
	logic        wdeEff;
	logic        wdieEff;
	logic        expire;
	logic        wrCause;
	logic        wrCtl;
	logic        chgOpen;
	logic        nWdeEff;

	assign rawIn = {wdAlwaysOnFuse, pinResetDisableFuse, undervoltEnableFuse, wdOscClk,
		undervoltDetect, powerupDetect, extResetPinN};

	// Raw sources gate the reset output without any clock; a pin pulse too short for
	// the synchroniser still resets pins but leaves no flag and no stretch
	assign rawActive = powerupDetect | (~extResetPinN & ~pinResetDisableFuse)
		| (undervoltDetect & undervoltEnableFuse);                          // [RULE_04] [RULE_06]
	assign resetN = ~(rawActive | r.wdPulse | r.inReset);                  // [RULE_02] [RULE_05] [RULE_07] [RULE_08]
	assign fetchStart = r.startPulse;
	assign refEnable = r.sync2[RWC_IN_UV_EN] | comparatorRefSelect | adcEnable; // [RULE_14]

	// Synchronised source levels; only the second stage is looked at
	assign pinAct   = ~r.sync2[RWC_IN_PIN_N] & ~r.sync2[RWC_IN_PIN_DIS];  // [RULE_06] [RULE_27]
	assign pwrAct   = r.sync2[RWC_IN_PWR];                                 // [RULE_27]
	assign uvAct    = r.sync2[RWC_IN_UV] & r.sync2[RWC_IN_UV_EN];         // [RULE_27]
	assign alwaysOn = r.sync2[RWC_IN_AON];
	assign anySrc   = pinAct | pwrAct | uvAct | r.wdPulse;                 // [RULE_04]
	assign oscRise  = r.sync2[RWC_IN_OSC] & ~r.oscPrev;                    // [RULE_15]

	// Effective watchdog mode with fuse and cause flag overrides
	assign wdeEff  = r.wd_reset_enable | r.flags[`RWC_CAUSE_WD] | alwaysOn;            // [RULE_19] [RULE_24]
	assign wdieEff = r.wd_irq_enable & ~alwaysOn;                                   // [RULE_19]
	assign expire  = oscRise & (wdeEff | wdieEff) & ~wdRestart
		& (r.wdCount == rwcLimit(r.sel) - `RWC_WD_CNT_W'(1));             // [RULE_22]

	// Bus writes land in the data phase of the captured address
	assign wrCause = r.selQ & r.writeQ & (r.addrQ == `RWC_OFS_CAUSE);
	assign wrCtl   = r.selQ & r.writeQ & (r.addrQ == `RWC_OFS_WDCTL);
	assign chgOpen = (r.ceCnt != 3'h0);

	// Zero wait states and always OKAY, so the master never stalls here
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = r.rdata;
	assign wdIrqReq  = r.irqFlag & wdieEff;                                // [RULE_17]

	assign nWdeEff = next_r.wd_reset_enable | next_r.flags[`RWC_CAUSE_WD] | alwaysOn;

	// Next-state logic for every register of the block except the quietCnt helper
	always_comb begin
		next_r = r;
		next_r.sync1   = rawIn;                                            // [RULE_27]
		next_r.sync2   = r.sync1;
		next_r.oscPrev = r.sync2[RWC_IN_OSC];
		next_r.wdPulse = 1'b0;

		// Stretcher: restart while any source is active, release after the quiet period
		next_r.startPulse = 1'b0;
		if (anySrc) begin
			next_r.inReset    = 1'b1;                                      // [RULE_03] [RULE_09]
			next_r.stretchCnt = '0;
		end else if (r.inReset) begin
			if (r.stretchCnt == SW'(STRETCH_CYCLES - 1)) begin             // [RULE_26]
				next_r.inReset    = 1'b0;
				next_r.startPulse = 1'b1;                                  // [RULE_01]
			end else begin
				next_r.stretchCnt = r.stretchCnt + SW'(1);                 // [RULE_03]
			end
		end

		// Cause flags: software writes only clear, hardware sets win over that clear
		if (wrCause)
			next_r.flags = r.flags & hwdata[3:0];
		if (r.wdPulse)
			next_r.flags[`RWC_CAUSE_WD] = 1'b1;                            // [RULE_10]
		if (uvAct)
			next_r.flags[`RWC_CAUSE_UV] = 1'b1;                            // [RULE_11]
		if (pinAct)
			next_r.flags[`RWC_CAUSE_PIN] = 1'b1;                           // [RULE_12]
		if (pwrAct) begin
			next_r.flags[3:1] = 3'h0;                                      // [RULE_10] [RULE_11] [RULE_12]
			next_r.flags[`RWC_CAUSE_PWR] = 1'b1;                           // [RULE_13]
		end

		// Change window counts down by itself
		next_r.ceCnt = chgOpen ? r.ceCnt - 3'h1 : 3'h0;                    // [RULE_23]

		// Control writes: reset enable may be cleared and time-out changed only in the window
		if (wrCtl) begin
			next_r.wd_irq_enable = hwdata[`RWC_CTL_IRQ_EN];
			if (hwdata[`RWC_CTL_IRQ_FLAG])
				next_r.irqFlag = 1'b0;                                     // [RULE_25]
			if (hwdata[`RWC_CTL_CHG_EN] & hwdata[`RWC_CTL_RST_EN]) begin
				next_r.ceCnt = `RWC_CHG_WINDOW;                            // [RULE_20] [RULE_23]
				next_r.wd_reset_enable   = 1'b1;
			end else if (chgOpen && !hwdata[`RWC_CTL_CHG_EN]) begin
				next_r.wd_reset_enable   = hwdata[`RWC_CTL_RST_EN];                    // [RULE_21]
				next_r.sel   = {hwdata[`RWC_CTL_SEL_HI], hwdata[`RWC_CTL_SEL_LO_MSB:0]};
				next_r.ceCnt = 3'h0;
			end else begin
				next_r.wd_reset_enable = r.wd_reset_enable | hwdata[`RWC_CTL_RST_EN];              // [RULE_21]
			end
		end

		// Taking the vector clears the flag; in combined mode it drops to reset-only
		if (wdIrqAck) begin
			next_r.irqFlag = 1'b0;                                         // [RULE_25]
			if (wdeEff)
				next_r.wd_irq_enable = 1'b0;                                        // [RULE_18]
		end

		// Watchdog counter on oscillator edges; restart from the core clears it
		if (wdRestart) begin
			next_r.wdCount = '0;                                           // [RULE_16]
		end else if (oscRise && (wdeEff || wdieEff)) begin
			next_r.wdCount = expire ? '0 : r.wdCount + `RWC_WD_CNT_W'(1);  // [RULE_15]
		end
		if (expire) begin
			if (wdieEff && !(wdeEff && r.irqFlag))
				next_r.irqFlag = 1'b1;                                     // [RULE_17] [RULE_18]
			else if (wdeEff)
				next_r.wdPulse = 1'b1;                                     // [RULE_09] [RULE_22]
		end

		// Internal reset returns the watchdog registers to their initial values
		if (anySrc || r.inReset) begin
			next_r.wd_reset_enable     = 1'b0;                                         // [RULE_01]
			next_r.wd_irq_enable    = 1'b0;
			next_r.irqFlag = 1'b0;
			next_r.sel     = '0;
			next_r.ceCnt   = 3'h0;
			next_r.wdCount = '0;
		end

		// Address phase capture; read data is taken from the updated state so a read
		// right after a write sees the written value
		next_r.selQ = hsel & htrans[1] & hready;
		if (hready) begin
			next_r.writeQ = hwrite;
			next_r.addrQ  = haddr[`RWC_ADDR_MSB:0];
		end
		next_r.rdata = '0;
		if (hsel && htrans[1] && hready && !hwrite) begin
			if (haddr[`RWC_ADDR_MSB:0] == `RWC_OFS_CAUSE)
				next_r.rdata = {28'h0000000, next_r.flags};
			else if (haddr[`RWC_ADDR_MSB:0] == `RWC_OFS_WDCTL)
				next_r.rdata = {24'h000000, next_r.irqFlag, next_r.wd_irq_enable & ~alwaysOn, next_r.sel[3],
					next_r.ceCnt != 3'h0, nWdeEff, next_r.sel[2:0]};       // [RULE_24]
		end
	end

	// State register; nrst is the power-up of the logic itself
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r                      <= '0;
			r.sync1[RWC_IN_PIN_N]  <= 1'b1;
			r.sync2[RWC_IN_PIN_N]  <= 1'b1;
			r.inReset              <= 1'b1;
			r.flags                <= `RWC_CAUSE_RST;
		end else begin
			r <= next_r;
		end
	end

	// Helper: cycles since the synchronised sources went quiet
	logic [SW:0] quietCnt;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			quietCnt <= '0;
		else if (anySrc)
			quietCnt <= '0;
		else if (quietCnt != {1'b1, {SW{1'b0}}})
			quietCnt <= quietCnt + (SW+1)'(1);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_open;
		wrCtl && hwdata[`RWC_CTL_CHG_EN] && hwdata[`RWC_CTL_RST_EN] && !anySrc && !r.inReset;
	endsequence
	// Four quiet cycles after opening, with no write that closes the window early
	sequence s_quiet;
		(!wrCtl && !anySrc && !r.inReset) [*4];
	endsequence
	sequence s_window;
		r.ceCnt == 3'h1 ##1 r.ceCnt == 3'h0;
	endsequence

	a_pin_reset_async: assert property (!extResetPinN && !pinResetDisableFuse |-> !resetN) // [RULE_02]
		else $error("pin reset did not assert reset output");
	a_powerup_immediate: assert property (powerupDetect |-> !resetN) // [RULE_07]
		else $error("power-on detect did not assert reset output");
	a_uv_immediate: assert property (undervoltDetect && undervoltEnableFuse |-> !resetN) // [RULE_08]
		else $error("undervolt detect did not assert reset output");
	a_wd_pulse_width: assert property (r.wdPulse |=> !r.wdPulse && r.inReset && r.flags[3]) // [RULE_09]
		else $error("watchdog pulse not one cycle or not recorded");
	a_stretch_release: assert property ($rose(resetN) |-> int'(quietCnt) == STRETCH_CYCLES) // [RULE_03]
		else $error("reset released after wrong stretch length");
	a_stretch_hold: assert property ($fell(anySrc) |-> !resetN ##1 !resetN) // [RULE_03]
		else $error("reset released without stretch");
	a_pin_flag_set: assert property (pinAct && !pwrAct |=> r.flags[1]) // [RULE_12]
		else $error("pin cause flag not set");
	a_uv_flag_set: assert property (uvAct && !pwrAct |=> r.flags[2]) // [RULE_11]
		else $error("undervolt cause flag not set");
	a_powerup_flag: assert property (pwrAct |=> r.flags == 4'h1) // [RULE_13]
		else $error("power-on did not set bit 0 and clear the others");
	a_powerup_keep: assert property ($fell(r.flags[0]) |-> $past(wrCause)) // [RULE_13]
		else $error("power-on flag cleared without software write");
	a_change_window: assert property (s_open ##1 s_quiet |-> s_window) // [RULE_23]
		else $error("change enable did not clear after four cycles");
	a_wde_override: assert property (r.flags[3] || alwaysOn |-> wdeEff) // [RULE_24]
		else $error("reset enable not held by flag or fuse");
	a_irq_mode: assert property (expire && wdieEff && !r.wd_reset_enable && !r.flags[3] && !alwaysOn && !anySrc
		&& !r.inReset |=> r.irqFlag && !r.wdPulse) // [RULE_17]
		else $error("interrupt mode expiry did not raise interrupt only");
endmodule : rwc_reset_watchdog

// ==== test/rwc_core_model.sv ====
// Far-side model: firmware restart and vector taking, reset pin, watchdog oscillator
`timescale 1ns/10ps
module rwc_core_model (
	input  wire logic clk,
	input  wire logic pinHold,
	input  wire logic restartOn,
	input  wire logic ackOn,
	input  wire logic wdIrqReq,
	output logic      extResetPinN,
	output logic      wdOscClk,
	output logic      wdRestart,
	output logic      wdIrqAck
);
	int tick = 0;
	// Own 128 kHz oscillator, phase unrelated to clk
	initial begin
		wdOscClk = 1'b0;
		#17;
		forever #3906.25 wdOscClk = ~wdOscClk;
	end
	// Pin held low for as long as asked, well past the minimum width
	assign extResetPinN = ~pinHold;
	// Firmware restarts far inside the time-out and takes the vector a little late
	initial begin
		wdRestart = 1'b0;
		wdIrqAck = 1'b0;
	end
	always @(posedge clk) begin
		tick <= tick + 1;
		wdRestart <= restartOn && (tick % 100 == 0);
		wdIrqAck <= ackOn && wdIrqReq && !wdIrqAck && (tick % 4 == 0);
	end
endmodule : rwc_core_model

// ==== test/tb_top.sv ====
// Self-checking bench of the reset and watchdog block over AHB-Lite
`timescale 1ns/10ps
`include "rwc_regs.svh"
module tb_top;
	import rwc_pkg::*;
	localparam int STRETCH = 8;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        pinHold = 1'b0;
	logic        restartOn = 1'b0;
	logic        ackOn = 1'b0;
	logic        powerupDetect = 1'b0;
	logic        undervoltDetect = 1'b0;
	logic        uvFuse = 1'b0;
	logic        pinDisFuse = 1'b0;
	logic        aonFuse = 1'b0;
	logic        cmpSel = 1'b0;
	logic        adcOn = 1'b0;
	logic [31:0] hrdata;
	logic        hready, hresp, extResetPinN, wdOscClk, wdRestart, wdIrqAck;
	logic        resetN, fetchStart, wdIrqReq, refEnable;
	logic [31:0] causeExp [3] = '{32'hc, 32'h1, 32'h3};
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;
	int          waited;

	rwc_reset_watchdog #(.STRETCH_CYCLES(STRETCH), .WD_BASE_CYCLES(4)) i_rwc_reset_watchdog (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .extResetPinN(extResetPinN), .powerupDetect(powerupDetect),
		.undervoltDetect(undervoltDetect), .wdOscClk(wdOscClk), .undervoltEnableFuse(uvFuse),
		.pinResetDisableFuse(pinDisFuse), .wdAlwaysOnFuse(aonFuse), .comparatorRefSelect(cmpSel),
		.adcEnable(adcOn), .wdRestart(wdRestart), .wdIrqAck(wdIrqAck), .resetN(resetN),
		.fetchStart(fetchStart), .wdIrqReq(wdIrqReq), .refEnable(refEnable));

	rwc_core_model i_rwc_core_model (
		.clk(clk), .pinHold(pinHold), .restartOn(restartOn), .ackOn(ackOn), .wdIrqReq(wdIrqReq),
		.extResetPinN(extResetPinN), .wdOscClk(wdOscClk), .wdRestart(wdRestart), .wdIrqAck(wdIrqAck));

	// 20 MHz system clock
	initial begin
		forever #25 clk = ~clk;
	end

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checks++;
		if (seen !== expected) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	// One single transfer; read data is taken at the data-phase edge where hready is high
	task automatic busCycle(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, addr};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wdata;
		do @(posedge clk); while (hready !== 1'b1);
		rdata = hrdata;
	endtask : busCycle

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] unused;
		busCycle(addr, 1'b1, data, unused);
	endtask : wr

	task automatic readCheck(input logic [7:0] addr, input logic [31:0] expected);
		logic [31:0] seen;
		busCycle(addr, 1'b0, 32'h0, seen);
		check(seen, expected);
	endtask : readCheck

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	// Bounded wait on the interrupt request or on the reset output resetN, sampled mid-cycle
	task automatic waitFor(input bit onReq, input logic lvl, input int limit);
		waited = 0;
		do begin
			@(negedge clk);
			waited++;
		end while ((onReq ? wdIrqReq : resetN) !== lvl && waited < limit);
	endtask : waitFor

	// Source levels: 0 undervolt, 1 power-on, 2 reset pin
	task automatic drive(input int src, input logic lvl);
		@(posedge clk);
		case (src)
			0: undervoltDetect <= lvl;
			1: powerupDetect <= lvl;
			default: pinHold <= lvl;
		endcase
	endtask : drive

	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		waitFor(0, 1'b1, 200);
		check(fetchStart, 1'b1);
		readCheck(`RWC_OFS_CAUSE, 32'h1);
		readCheck(`RWC_OFS_WDCTL, 32'h0);
		readCheck(8'h08, 32'h0);
		wr(`RWC_OFS_CAUSE, 32'h0);
		readCheck(`RWC_OFS_CAUSE, 32'h0);
		// Reference enable follows each requester in turn
		@(posedge clk) cmpSel <= 1'b1;
		@(negedge clk) check(refEnable, 1'b1);
		@(posedge clk) cmpSel <= 1'b0;
		@(negedge clk) check(refEnable, 1'b0);
		@(posedge clk) adcOn <= 1'b1;
		@(negedge clk) check(refEnable, 1'b1);
		@(posedge clk) adcOn <= 1'b0;
		@(posedge clk) uvFuse <= 1'b1;
		idle(4);
		@(negedge clk) check(refEnable, 1'b1);
		// Timed change: inside the window, outside it, and the window closing by itself
		wr(`RWC_OFS_WDCTL, 32'h18);
		wr(`RWC_OFS_WDCTL, 32'h21);
		readCheck(`RWC_OFS_WDCTL, 32'h21);
		wr(`RWC_OFS_WDCTL, 32'h02);
		readCheck(`RWC_OFS_WDCTL, 32'h21);
		wr(`RWC_OFS_WDCTL, 32'h18);
		idle(6);
		readCheck(`RWC_OFS_WDCTL, 32'h29);
		wr(`RWC_OFS_WDCTL, 32'h18);
		wr(`RWC_OFS_WDCTL, 32'h00);
		readCheck(`RWC_OFS_WDCTL, 32'h00);
		// Always-on fuse locks the mode bits
		@(posedge clk) aonFuse <= 1'b1;
		idle(4);
		wr(`RWC_OFS_WDCTL, 32'h40);
		readCheck(`RWC_OFS_WDCTL, 32'h08);
		@(posedge clk) aonFuse <= 1'b0;
		idle(4);
		wr(`RWC_OFS_WDCTL, 32'h00);
		// Interrupt mode: restarts hold it off, then expiry interrupts without reset
		@(posedge clk) restartOn <= 1'b1;
		wr(`RWC_OFS_WDCTL, 32'h40);
		idle(1500);
		check(wdIrqReq, 1'b0);
		@(posedge clk) restartOn <= 1'b0;
		waitFor(1, 1'b1, 3000);
		check(wdIrqReq, 1'b1);
		check(resetN, 1'b1);
		wr(`RWC_OFS_WDCTL, 32'hc0);
		@(negedge clk) check(wdIrqReq, 1'b0);
		// Combined mode: interrupt, vector taken, then the next expiry resets
		wr(`RWC_OFS_WDCTL, 32'h48);
		waitFor(1, 1'b1, 3000);
		check(resetN, 1'b1);
		@(posedge clk) ackOn <= 1'b1;
		waitFor(1, 1'b0, 50);
		@(posedge clk) ackOn <= 1'b0;
		readCheck(`RWC_OFS_WDCTL, 32'h08);
		waitFor(0, 1'b0, 3000);
		check(resetN, 1'b0);
		waitFor(0, 1'b1, 200);
		readCheck(`RWC_OFS_CAUSE, 32'h8);
		readCheck(`RWC_OFS_WDCTL, 32'h08);
		// Each analog or pin source: immediate reset, stretched release, cause flags
		for (int s = 0; s < 3; s++) begin
			drive(s, 1'b1);
			@(negedge clk) check(resetN, 1'b0);
			idle(10);
			drive(s, 1'b0);
			waitFor(0, 1'b1, 200);
			check(waited >= STRETCH && waited <= STRETCH + 4, 1'b1);
			check(fetchStart, 1'b1);
			readCheck(`RWC_OFS_CAUSE, causeExp[s]);
		end
		readCheck(`RWC_OFS_WDCTL, 32'h00);
		// Disabled pin and disabled detector are no reset sources
		@(posedge clk) pinDisFuse <= 1'b1;
		@(posedge clk) uvFuse <= 1'b0;
		idle(4);
		drive(2, 1'b1);
		drive(0, 1'b1);
		idle(10);
		check(resetN, 1'b1);
		drive(2, 1'b0);
		drive(0, 1'b0);
		idle(5);
		readCheck(`RWC_OFS_CAUSE, 32'h3);
		conclude();
	end
endmodule : tb_top
